/* File: design/bbirq_core.sv */
// baseband core interrupt generation and phy control register
`timescale 1ns/1ps
module bbirq_core
    import bbirq_pkg::*;
#(
    parameter int LEN_W = 11
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic preambleFound,
    input wire logic frameStart,
    input wire logic headerValid,
    input wire logic headerMissing,
    input wire logic signalBreak,
    input wire logic [LEN_W-1:0] headerLength,
    input wire logic addrFilterEnable,
    input wire logic macParseDone,
    input wire logic frameExtended,
    input wire logic frameMatching,
    input wire logic firstFilterPass,
    input wire logic checkOk,
    input wire logic frameDone,
    input wire logic octetStored,
    input wire logic txLastSent,
    output logic gainHold,
    output logic txPrepare,
    output logic rxRestart,
    output logic continuousTx,
    output logic [1:0] phySelect,
    output logic basebandOn,
    output logic irq
);
    logic [7:0] phyControl_r;
    logic [7:0] mask_r;
    logic [7:0] lenLow_r;
    logic [2:0] lenHigh_r;
    logic [7:0] thrLow_r;
    logic [2:0] thrHigh_r;
    logic [LEN_W-1:0] octets_r;
    logic rxActive_r;
    logic suppress_r;
    logic [7:0] delay_r;
    logic delayRun_r;
    logic pendOk_r;
    logic gainHold_r;
    logic [7:0] events;
    logic [7:0] status;
    logic cancel;
    logic readClear;
    logic enabled;
    logic rxLive;
    logic delayLast;
    logic frameEndStart;
    logic [10:0] threshold;
    logic [7:0] pending;
    logic wrPhy;
    logic wrMask;
    logic wrThrLow;
    logic wrThrHigh;
    bbirq_event_if ev ();

    // one register port strobe aimed at one index
    function automatic logic portHit(input logic strobe, input logic [3:0] a,
        input logic [3:0] idx);
        return strobe && (a == idx);
    endfunction

    // write strobes per register
    assign wrPhy = portHit(regWrite, regAddr, REG_PHY_CONTROL);
    assign wrMask = portHit(regWrite, regAddr, REG_IRQ_MASK);
    assign wrThrLow = portHit(regWrite, regAddr, REG_LEVEL_LOW);
    assign wrThrHigh = portHit(regWrite, regAddr, REG_LEVEL_HIGH);

    assign enabled = phyControl_r[PC_BB_ENABLE] && (phyControl_r[1:0] != PHY_OFF);
    // cancel on break or missing header during an active reception
    assign cancel = rxActive_r && (signalBreak || headerMissing);
    // header, extended and match events pass only in a live, uncancelled reception
    assign rxLive = rxActive_r && !suppress_r && !cancel;
    // last count of the frame end delay
    assign delayLast = delayRun_r && (delay_r == 8'h01);
    // frame end seen in a reception with no delay running yet
    assign frameEndStart = frameDone && rxActive_r && !delayRun_r && !cancel;
    // octet count at which the level event fires
    assign threshold = {thrHigh_r, thrLow_r};

    // event strobes, receive events suppressed after cancel
    always_comb begin
        events = 8'h00;
        if (enabled) begin
            events[IRQ_HEADER] = headerValid && rxLive;
            events[IRQ_EXTENDED] = addrFilterEnable && macParseDone && frameExtended
                && rxLive;
            events[IRQ_MATCH] = addrFilterEnable && macParseDone && frameMatching
                && rxLive;
            events[IRQ_FRAME_END] = delayLast && pendOk_r;
            events[IRQ_TX_END] = txLastSent;
            events[IRQ_GAIN_HOLD] = preambleFound && !rxActive_r;
            events[IRQ_GAIN_REL] = cancel || delayLast;
            events[IRQ_LEVEL] = octetStored && !suppress_r
                && ((octets_r + 1'b1) == threshold);
        end
    end

    assign ev.events = events;
    assign ev.lenCaptured = headerLength;
    assign ev.lenLoad = events[IRQ_HEADER];
    assign readClear = portHit(regRead, regAddr, REG_IRQ_STATUS);

    bbirq_status statusUnit (
        .clk(clk),
        .nrst(nrst),
        .ev(ev.dst),
        .readClear(readClear),
        .status(status)
    );

    // receive activity: set by gain hold, dropped on release or cancel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxActive_r <= 1'b0;
        end else if (cancel || events[IRQ_GAIN_REL]) begin
            rxActive_r <= 1'b0;
        end else if (events[IRQ_GAIN_HOLD]) begin
            rxActive_r <= 1'b1;
        end
    end

    // suppression: set on cancel, lifted by the next gain hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            suppress_r <= 1'b0;
        end else if (cancel) begin
            suppress_r <= 1'b1;
        end else if (events[IRQ_GAIN_HOLD]) begin
            suppress_r <= 1'b0;
        end
    end

    // frame end delay counter, dropped on cancel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            delay_r <= 8'h00;
            delayRun_r <= 1'b0;
        end else if (cancel) begin
            delayRun_r <= 1'b0;
            delay_r <= 8'h00;
        end else if (frameEndStart) begin
            delayRun_r <= 1'b1;
            delay_r <= 8'(FRAME_END_CYCLES);
        end else if (delayRun_r) begin
            delay_r <= delay_r - 8'h01;
            if (delay_r == 8'h01) begin
                delayRun_r <= 1'b0;
            end
        end
    end

    // filter verdict taken when the frame ends
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pendOk_r <= 1'b0;
        end else if (frameEndStart) begin
            pendOk_r <= firstFilterPass && (!addrFilterEnable || frameMatching)
                && (!phyControl_r[PC_CHECK_FILTER] || checkOk) && !suppress_r;
        end
    end

    // stored octet count, restarted at frame start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            octets_r <= '0;
        end else if (frameStart) begin
            octets_r <= '0;
        end else if (octetStored) begin
            octets_r <= octets_r + 1'b1;
        end
    end

    // received length, low part
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lenLow_r <= 8'h00;
        end else if (ev.lenLoad) begin
            lenLow_r <= ev.lenCaptured[7:0];
        end
    end

    // received length, high part
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lenHigh_r <= 3'h0;
        end else if (ev.lenLoad) begin
            lenHigh_r <= ev.lenCaptured[10:8];
        end
    end

    // gain controller hold level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gainHold_r <= 1'b0;
        end else if (events[IRQ_GAIN_REL]) begin
            gainHold_r <= 1'b0;
        end else if (events[IRQ_GAIN_HOLD]) begin
            gainHold_r <= 1'b1;
        end
    end

    // phy control register, check-valid hardware owned
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phyControl_r <= PHY_CONTROL_RST;
        end else begin
            if (wrPhy) begin
                phyControl_r[7:6] <= regWdata[7:6];
                phyControl_r[4:0] <= regWdata[4:0];
            end
            if (frameStart) begin
                phyControl_r[PC_CHECK_VALID] <= 1'b0;
            end else if (frameDone && rxActive_r) begin
                phyControl_r[PC_CHECK_VALID] <= checkOk;
            end
        end
    end

    // interrupt mask register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mask_r <= IRQ_MASK_RST;
        end else if (wrMask) begin
            mask_r <= regWdata;
        end
    end

    // level threshold, low part
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thrLow_r <= LEVEL_THRESH_RST[7:0];
        end else if (wrThrLow) begin
            thrLow_r <= regWdata;
        end
    end

    // level threshold, high part
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thrHigh_r <= LEVEL_THRESH_RST[10:8];
        end else if (wrThrHigh) begin
            thrHigh_r <= regWdata[2:0];
        end
    end

    // read data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                REG_PHY_CONTROL: regRdata <= phyControl_r;
                REG_IRQ_STATUS: regRdata <= status;
                REG_IRQ_MASK: regRdata <= mask_r;
                REG_RX_LEN_LOW: regRdata <= lenLow_r;
                REG_RX_LEN_HIGH: regRdata <= {5'h00, lenHigh_r};
                REG_LEVEL_LOW: regRdata <= thrLow_r;
                REG_LEVEL_HIGH: regRdata <= {5'h00, thrHigh_r};
                default: regRdata <= 8'h00;
            endcase
        end
    end

    // per-bit gating of status by mask
    for (genvar gi = 0; gi < 8; gi++) begin : gPending
        assign pending[gi] = status[gi] && mask_r[gi];
    end
    assign irq = |pending;
    assign txPrepare = events[IRQ_FRAME_END];
    assign rxRestart = events[IRQ_GAIN_REL];
    assign gainHold = gainHold_r;
    assign continuousTx = phyControl_r[PC_CONT_TX];
    assign phySelect = phyControl_r[PC_PHY_HI:0];
    assign basebandOn = enabled;
endmodule

/* File: design/bbirq_event_if.sv */
// event strobes from the receive engine to the status register
`timescale 1ns/1ps
interface bbirq_event_if;
    logic [7:0] events;
    logic [10:0] lenCaptured;
    logic lenLoad;
    modport src (output events, output lenCaptured, output lenLoad);
    modport dst (input events, input lenCaptured, input lenLoad);
endinterface

/* File: design/bbirq_pkg.sv */
// constants and types for the baseband interrupt and phy control block
// Overview of operation
// - raise header-found event as soon as a valid phy header is detected
// - on header-found, latch received frame length high and low parts
// - raise frame-end event a fixed delay after frame end, payload stored
// - with frame-end, leave receive and enter transmit preparation on its own
// - frame-end only if first filter passes and, with address filter, match
// - with address filter, raise extended-frame event when header parse completes
// - with address filter, raise address-match event when header parse completes
// - raise transmit-end event when the last part of a frame has been sent
// - preamble detected: raise gain-hold event and tell gain control to freeze
// - receive finished or cancelled: raise gain-release and resume gain control
// - gain-release during frame receive cancels and restarts reception
// - gain-hold and gain-release clear each other, status keeps the newest
// - buffer-level event when stored octet count reaches the threshold registers
// - after cancel, suppress remaining receive events until restart
// - cancel reception on signal discontinuity or missing valid header
// - phy control is 8 bits, check-valid read-only, reset pattern 0x54
// - bit 7 of phy control enables continuous transmit
// - the core keeps its own status and mask registers, mask gates events; the code masks only the irq output, status sets on every event
// - phy select field: 0 off, 1 fsk, 2 ofdm, 3 offset-qpsk variants
// - check-valid clears on frame start, updated when whole frame received
package bbirq_pkg;
    // register indices on the register port
    localparam logic [3:0] REG_PHY_CONTROL = 4'h0;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
    localparam logic [3:0] REG_IRQ_MASK = 4'h2;
    localparam logic [3:0] REG_RX_LEN_LOW = 4'h3;
    localparam logic [3:0] REG_RX_LEN_HIGH = 4'h4;
    localparam logic [3:0] REG_LEVEL_LOW = 4'h5;
    localparam logic [3:0] REG_LEVEL_HIGH = 4'h6;
    // status bit positions
    localparam int IRQ_HEADER = 0;
    localparam int IRQ_FRAME_END = 1;
    localparam int IRQ_EXTENDED = 2;
    localparam int IRQ_MATCH = 3;
    localparam int IRQ_TX_END = 4;
    localparam int IRQ_GAIN_HOLD = 5;
    localparam int IRQ_GAIN_REL = 6;
    localparam int IRQ_LEVEL = 7;
    // phy control field positions
    localparam int PC_CONT_TX = 7;
    localparam int PC_CHECK_FILTER = 6;
    localparam int PC_CHECK_VALID = 5;
    localparam int PC_AUTO_CHECK = 4;
    localparam int PC_CHECK_TYPE = 3;
    localparam int PC_BB_ENABLE = 2;
    localparam int PC_PHY_HI = 1;
    // reset values
    localparam logic [7:0] PHY_CONTROL_RST = 8'h54;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;
    localparam logic [10:0] LEVEL_THRESH_RST = 11'h000;
    // frame-end delay after frame end
    localparam int FRAME_END_DELAY_NS = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int FRAME_END_CYCLES = (FRAME_END_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // phy select encodings
    typedef enum logic [1:0] {
        PHY_OFF = 2'h0,
        PHY_FSK = 2'h1,
        PHY_OFDM = 2'h2,
        PHY_OQPSK = 2'h3
    } bbirq_phy_e;
endpackage

/* File: design/bbirq_status.sv */
// sticky interrupt status with mutual gain-hold / gain-release exclusion
`timescale 1ns/1ps
module bbirq_status
    import bbirq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    bbirq_event_if.dst ev,
    input wire logic readClear,
    output logic [7:0] status
);
    logic [7:0] status_r;
    logic [7:0] status_nxt;

    // set wins over read clear; hold and release cancel each other
    always_comb begin
        status_nxt = readClear ? 8'h00 : status_r;
        status_nxt = status_nxt | ev.events;
        if (ev.events[IRQ_GAIN_HOLD]) begin
            status_nxt[IRQ_GAIN_REL] = 1'b0;
        end
        if (ev.events[IRQ_GAIN_REL]) begin
            status_nxt[IRQ_GAIN_HOLD] = 1'b0;
        end
    end

    // status register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= 8'h00;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign status = status_r;
endmodule

/* File: test/bbirq_core_asserts.sv */
// port checker for the baseband interrupt core
`timescale 1ns/1ps
module bbirq_core_asserts
    import bbirq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic preambleFound,
    input wire logic headerMissing,
    input wire logic signalBreak,
    input wire logic frameDone,
    input wire logic gainHold,
    input wire logic txPrepare,
    input wire logic rxRestart,
    input wire logic continuousTx,
    input wire logic [1:0] phySelect,
    input wire logic basebandOn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // register port and receive sequencing
    AST_CTX: assert property (
        regWrite && regAddr == REG_PHY_CONTROL |=> continuousTx == $past(regWdata[7]))
        else $error("continuous transmit not from write");
    AST_PHY: assert property (
        regWrite && regAddr == REG_PHY_CONTROL |=> phySelect == $past(regWdata[1:0])
        && basebandOn == ($past(regWdata[2]) && $past(regWdata[1:0]) != 2'h0))
        else $error("phy select or enable wrong");
    AST_UNMAP: assert property (
        regRead && regAddr > REG_LEVEL_HIGH |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_STAND: assert property (
        !regRead |=> $stable(regRdata)) else $error("read data moved");
    AST_HOLD: assert property (
        preambleFound && basebandOn && !gainHold && !signalBreak && !headerMissing
        && !frameDone |=> gainHold) else $error("gain hold not raised");
    AST_BREAK: assert property (
        (signalBreak || headerMissing) && gainHold && basebandOn |-> ##[0:1] rxRestart)
        else $error("cancel without restart");
    AST_REL: assert property (
        rxRestart && !preambleFound |=> !gainHold) else $error("hold kept after release");
    AST_PREP: assert property (
        txPrepare |-> rxRestart) else $error("tx prepare without release");
    AST_DELAY: assert property (
        txPrepare |-> $past(frameDone, 9) || $past(frameDone, 10) || $past(frameDone, 11))
        else $error("frame end delay wrong");
    // main scenarios
    COV_PREP: cover property (txPrepare);
    COV_CANCEL: cover property (rxRestart && !txPrepare);
    COV_UNMAP: cover property (regRead && regAddr > REG_LEVEL_HIGH);
endmodule
bind bbirq_core bbirq_core_asserts i_bbirq_core_asserts (.clk(clk), .nrst(nrst),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .preambleFound(preambleFound), .headerMissing(headerMissing),
    .signalBreak(signalBreak), .frameDone(frameDone), .gainHold(gainHold),
    .txPrepare(txPrepare), .rxRestart(rxRestart), .continuousTx(continuousTx),
    .phySelect(phySelect), .basebandOn(basebandOn));

/* File: test/bbirq_core_tb.sv */
// testbench for the baseband interrupt core
`timescale 1ns/1ps
module bbirq_core_tb;
    import bbirq_pkg::*;
    logic clk, nrst, addrFilterEnable, frameExtended, frameMatching, firstFilterPass, checkOk;
    logic [8:0] ev;
    logic [10:0] headerLength;
    logic regWrite, regRead, gainHold, txPrepare, rxRestart, continuousTx, basebandOn, irq;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata;
    logic [1:0] phySelect;
    int n_errors, n_compared, cyc;
    bbirq_host i_bbirq_host (.clk, .regWrite, .regRead, .regAddr, .regWdata, .regRdata);
    bbirq_core i_bbirq_core (.clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .preambleFound(ev[0]), .frameStart(ev[1]), .headerValid(ev[2]),
        .headerMissing(ev[3]), .signalBreak(ev[4]), .headerLength, .addrFilterEnable,
        .macParseDone(ev[5]), .frameExtended, .frameMatching, .firstFilterPass, .checkOk,
        .frameDone(ev[6]), .octetStored(ev[7]), .txLastSent(ev[8]), .gainHold, .txPrepare,
        .rxRestart, .continuousTx, .phySelect, .basebandOn, .irq);
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    task automatic results();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", n, exp, seen);
            n_errors++;
        end
    endtask
    task automatic expect_reg(input string n, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_bbirq_host.rd(a, d);
        check(n, d, e);
    endtask
    // one-cycle event strobe
    task automatic pulse(input int b);
        @(posedge clk);
        #1;
        ev[b] = 1'b1;
        @(posedge clk);
        #1;
        ev[b] = 1'b0;
    endtask
    // main sequence
    initial begin
        nrst = 1'b0;
        ev = 9'h000;
        headerLength = 11'h5a3;
        {addrFilterEnable, frameExtended, frameMatching, firstFilterPass, checkOk} = 5'h1f;
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        expect_reg("pc reset", REG_PHY_CONTROL, 8'h54);
        expect_reg("mask reset", REG_IRQ_MASK, 8'h00);
        i_bbirq_host.wr(REG_PHY_CONTROL, 8'hff);
        expect_reg("pc read only", REG_PHY_CONTROL, 8'hdf);
        check("continuousTx", continuousTx, 1'b1);
        for (int p = 0; p < 4; p++) begin
            i_bbirq_host.wr(REG_PHY_CONTROL, 8'h54 | p[7:0]);
            check("phySelect", phySelect, p[1:0]);
            check("basebandOn", basebandOn, p != 0);
        end
        expect_reg("unmapped", 4'hf, 8'h00);
        i_bbirq_host.wr(REG_IRQ_MASK, 8'hff);
        i_bbirq_host.wr(REG_LEVEL_LOW, 8'h02);
        i_bbirq_host.wr(REG_LEVEL_HIGH, 8'h00);
        pulse(0);
        check("gainHold", gainHold, 1'b1);
        pulse(1);
        pulse(2);
        expect_reg("len low", REG_RX_LEN_LOW, 8'ha3);
        expect_reg("len high", REG_RX_LEN_HIGH, 8'h05);
        expect_reg("status header", REG_IRQ_STATUS, 8'h21);
        check("irq cleared", irq, 1'b0);
        pulse(5);
        pulse(7);
        pulse(7);
        pulse(6);
        // frame end strobe stands in the tenth cycle after frame done
        repeat (9) @(posedge clk);
        #1;
        check("txPrepare", txPrepare, 1'b1);
        check("rxRestart", rxRestart, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        check("irq", irq, 1'b1);
        check("gainHold off", gainHold, 1'b0);
        expect_reg("status end", REG_IRQ_STATUS, 8'hce);
        expect_reg("check valid", REG_PHY_CONTROL, 8'h77);
        pulse(8);
        expect_reg("status tx", REG_IRQ_STATUS, 8'h10);
        // break, missing header, failed filter
        for (int c = 0; c < 3; c++) begin
            i_bbirq_host.wr(REG_IRQ_MASK, c == 2 ? 8'h00 : 8'hff);
            frameMatching = c != 2;
            frameExtended = c != 2;
            pulse(0);
            pulse(1);
            expect_reg("check cleared", REG_PHY_CONTROL, 8'h57);
            pulse(2);
            if (c < 2) pulse(c == 0 ? 4 : 3);
            // level reached after a cancel must stay silent
            pulse(7);
            pulse(7);
            pulse(5);
            pulse(6);
            repeat (12) @(posedge clk);
            #1;
            check("irq masked", irq, c != 2);
            expect_reg("status cut", REG_IRQ_STATUS, c == 2 ? 8'hc1 : 8'h41);
        end
        results();
    end
endmodule

/* File: test/bbirq_host.sv */
// host model driving the core register port
`timescale 1ns/1ps
module bbirq_host (
    input wire logic clk,
    output logic regWrite,
    output logic regRead,
    output logic [3:0] regAddr,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    // idle port at time zero
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 4'h0;
        regWdata = 8'h00;
    end
    // one write, held until the taking edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regWdata = ~d; // released data no longer valid
    endtask
    // one read, data registered at the taking edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        regRead = 1'b1;
        regAddr = a;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        d = regRdata;
    endtask
endmodule
